// ==== rtl/pxa_pkg.sv ====
// Shared constants and types for the pixel SIMD add unit
package pxa_pkg;

	// ==========================================================
	// Operation select, one-hot
	// ==========================================================
	typedef enum logic [2:0] {
		PXA_OP_ADD_CLIP = 3'b001,
		PXA_OP_ACC_EXT  = 3'b010,
		PXA_OP_QUAD_ADD = 3'b100
	} pxa_op_t;

	// ==========================================================
	// Widths
	// ==========================================================
	localparam int WORD_W  = 32;
	localparam int BYTE_W  = 8;
	localparam int HALF_W  = 16;
	localparam int ALIGN_W = 2;
	localparam int ACC_W   = 40;

	// ==========================================================
	// Pair names and byte alignment codes
	// ==========================================================
	localparam logic PAIR_R10 = 1'b0;
	localparam logic PAIR_R32 = 1'b1;

	localparam logic [1:0] ALIGN_B3_0 = 2'h0;
	localparam logic [1:0] ALIGN_B4_1 = 2'h1;
	localparam logic [1:0] ALIGN_B5_2 = 2'h2;
	localparam logic [1:0] ALIGN_B6_3 = 2'h3;

	// ==========================================================
	// Clip range and field positions
	// ==========================================================
	localparam logic [31:0] CLIP_MAX  = 32'h0000_00ff;
	localparam logic [7:0]  BYTE_ZERO = 8'h00;
	localparam logic [7:0]  BYTE_FULL = 8'hff;
	localparam int LANE0_LSB = 0;
	localparam int LANE1_LSB = 8;
	localparam int LANE2_LSB = 16;
	localparam int LANE3_LSB = 24;
	localparam int HALF_HI_LSB = 16;

	// ==========================================================
	// Reset values
	// ==========================================================
	localparam logic [31:0] DEST_RESET = 32'h0000_0000;

endpackage : pxa_pkg

// ==== rtl/pxa_byte_align.sv ====
// Four-byte window taken from an eight-byte register pair
`timescale 1ns/100ps
module pxa_byte_align (
	input  wire logic [31:0] lowWord,
	input  wire logic [31:0] highWord,
	input  wire logic [1:0]  align,
	input  wire logic        reversePair,
	output logic      [31:0] aligned
);

	// ==========================================================
	// Pair ordering and byte window
	// ==========================================================
	logic [63:0] pairBytes;
	logic [63:0] shifted;

	always_comb begin
		if (reversePair) begin
			pairBytes = {lowWord, highWord};
		end else begin
			pairBytes = {highWord, lowWord};
		end
	end

	// Alignment n picks bytes n+3..n
	always_comb begin
		shifted = pairBytes >> {align, 3'b000};
	end

	assign aligned = shifted[31:0];

endmodule : pxa_byte_align

// ==== rtl/pxa_simd_unit.sv ====
// Pixel SIMD add unit: add/clip, accumulator extraction, quad add
`timescale 1ns/100ps
module pxa_simd_unit #(
	parameter int ACC_WIDTH = pxa_pkg::ACC_W
) (
	input  wire logic                 core_clk,
	input  wire logic                 srst,
	input  wire logic                 opValid,
	input  wire pxa_pkg::pxa_op_t     opSel,
	input  wire logic                 highBytePlacement,
	input  wire logic                 reversePairOrder,
	input  wire logic                 srcZeroPair,
	input  wire logic                 srcOnePair,
	input  wire logic [31:0]          pairZeroLow,
	input  wire logic [31:0]          pairZeroHigh,
	input  wire logic [31:0]          pairOneLow,
	input  wire logic [31:0]          pairOneHigh,
	input  wire logic [31:0]          indexRegZero,
	input  wire logic [31:0]          indexRegOne,
	input  wire logic [ACC_WIDTH-1:0] accumulatorZero,
	input  wire logic [ACC_WIDTH-1:0] accumulatorOne,
	output logic                      resultValid,
	output logic [31:0]               destZero,
	output logic [31:0]               destOne,
	output logic                      destOneWrite,
	output logic                      alignExcSuppress
);

	// ==========================================================
	// Pair alignment
	// ==========================================================
	logic [31:0] alignedPairZero;
	logic [31:0] alignedPairOne;
	logic [31:0] ySrc;
	logic [31:0] zSrc;

	// Each pair has its own index register
	pxa_byte_align u_alignPairZero (
		.lowWord     (pairZeroLow),
		.highWord    (pairZeroHigh),
		.align       (indexRegZero[1:0]),
		.reversePair (reversePairOrder),
		.aligned     (alignedPairZero)
	);

	pxa_byte_align u_alignPairOne (
		.lowWord     (pairOneLow),
		.highWord    (pairOneHigh),
		.align       (indexRegOne[1:0]),
		.reversePair (reversePairOrder),
		.aligned     (alignedPairOne)
	);

	// One select bit per source: no other pairing can be named
	always_comb begin
		ySrc = (srcZeroPair == pxa_pkg::PAIR_R32) ? alignedPairOne
			: alignedPairZero;
		zSrc = (srcOnePair == pxa_pkg::PAIR_R32) ? alignedPairOne
			: alignedPairZero;
	end

	// ==========================================================
	// Dual add / clip
	// ==========================================================
	function automatic logic [7:0] clip8(input logic signed [31:0] s);
		logic [7:0] r;
		r = s[7:0];
		if (s < 0) begin
			r = pxa_pkg::BYTE_ZERO;
		end else if (s > $signed(pxa_pkg::CLIP_MAX)) begin
			r = pxa_pkg::BYTE_FULL;
		end
		return r;
	endfunction : clip8

	logic signed [31:0] sumHi;
	logic signed [31:0] sumLo;
	logic        [7:0]  clipHi;
	logic        [7:0]  clipLo;
	logic        [31:0] clipWord;

	// Residual is signed; byte is widened with zeros
	always_comb begin
		sumHi = $signed({24'h000000, ySrc[15:8]})
			+ $signed({{16{zSrc[31]}}, zSrc[31:16]});
		sumLo = $signed({24'h000000, ySrc[7:0]})
			+ $signed({{16{zSrc[15]}}, zSrc[15:0]});
		clipHi = clip8(sumHi);
		clipLo = clip8(sumLo);
	end

	always_comb begin
		if (highBytePlacement) begin
			clipWord = {clipHi, pxa_pkg::BYTE_ZERO,
				clipLo, pxa_pkg::BYTE_ZERO};
		end else begin
			clipWord = {pxa_pkg::BYTE_ZERO, clipHi,
				pxa_pkg::BYTE_ZERO, clipLo};
		end
	end

	// ==========================================================
	// Accumulator extraction
	// ==========================================================
	logic [31:0] accSumZero;
	logic [31:0] accSumOne;

	// Halves may carry past 16 bits, so the full word is kept
	always_comb begin
		accSumZero = {{16{accumulatorZero[31]}}, accumulatorZero[31:16]}
			+ {{16{accumulatorZero[15]}}, accumulatorZero[15:0]};
		accSumOne = {{16{accumulatorOne[31]}}, accumulatorOne[31:16]}
			+ {{16{accumulatorOne[15]}}, accumulatorOne[15:0]};
	end

	// ==========================================================
	// Quad byte add
	// ==========================================================
	logic [15:0] laneSum [4];

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			laneSum[i] = {8'h00, ySrc[i*8 +: 8]}
				+ {8'h00, zSrc[i*8 +: 8]};
		end
	end

	// ==========================================================
	// Result registers
	// ==========================================================
	logic        resultValid_q;
	logic [31:0] destZero_q;
	logic [31:0] destOne_q;
	logic        destOneWrite_q;
	logic        alignExcSuppress_q;

	// Fully pipelined: no busy state, a new op every cycle
	always_ff @(posedge core_clk) begin
		if (srst) begin
			resultValid_q  <= 1'b0;
			destOneWrite_q <= 1'b0;
		end else begin
			resultValid_q  <= opValid;
			destOneWrite_q <= opValid
				&& (opSel != pxa_pkg::PXA_OP_ADD_CLIP);
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			destZero_q <= pxa_pkg::DEST_RESET;
			destOne_q  <= pxa_pkg::DEST_RESET;
		end else if (opValid) begin
			case (opSel)
				pxa_pkg::PXA_OP_ADD_CLIP: begin
					destZero_q <= clipWord;
					destOne_q  <= pxa_pkg::DEST_RESET;
				end
				pxa_pkg::PXA_OP_ACC_EXT: begin
					destZero_q <= accSumZero;
					destOne_q  <= accSumOne;
				end
				pxa_pkg::PXA_OP_QUAD_ADD: begin
					destZero_q <= {laneSum[1], laneSum[0]};
					destOne_q  <= {laneSum[3], laneSum[2]};
				end
				default: begin
					destZero_q <= pxa_pkg::DEST_RESET;
					destOne_q  <= pxa_pkg::DEST_RESET;
				end
			endcase
		end
	end

	// Loads issued beside a pixel byte op are not trapped
	always_ff @(posedge core_clk) begin
		if (srst) begin
			alignExcSuppress_q <= 1'b0;
		end else begin
			alignExcSuppress_q <= opValid
				&& (opSel != pxa_pkg::PXA_OP_ACC_EXT);
		end
	end

	assign resultValid      = resultValid_q;
	assign destZero         = destZero_q;
	assign destOne          = destOne_q;
	assign destOneWrite     = destOneWrite_q;
	assign alignExcSuppress = alignExcSuppress_q;

	// ==========================================================
	// Assertions
	// ==========================================================
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	logic isClip;
	logic isAcc;
	logic isQuad;
	assign isClip = opValid && (opSel == pxa_pkg::PXA_OP_ADD_CLIP);
	assign isAcc  = opValid && (opSel == pxa_pkg::PXA_OP_ACC_EXT);
	assign isQuad = opValid && (opSel == pxa_pkg::PXA_OP_QUAD_ADD);

	a_clip_neg_zero: assert property (
		isClip && !highBytePlacement && (sumHi < 0)
		|=> destZero[23:16] == 8'h00)
		else $error("negative add/clip sum not clipped to zero");

	a_clip_sat_max: assert property (
		isClip && !highBytePlacement && (sumLo > 32'sh0000_00ff)
		|=> destZero[7:0] == 8'hff)
		else $error("add/clip sum above range not clipped to 255");

	a_clip_low_place: assert property (
		isClip && !highBytePlacement
		|=> destZero[23:16] == $past(clipHi)
			&& destZero[7:0] == $past(clipLo))
		else $error("low placement bytes wrong");

	a_clip_high_place: assert property (
		isClip && highBytePlacement
		|=> destZero[31:24] == $past(clipHi)
			&& destZero[15:8] == $past(clipLo))
		else $error("high placement bytes wrong");

	a_clip_zero_fill: assert property (
		isClip
		|=> ($past(highBytePlacement)
			? (destZero[23:16] == 8'h00 && destZero[7:0] == 8'h00)
			: (destZero[31:24] == 8'h00 && destZero[15:8] == 8'h00)))
		else $error("unused add/clip byte not zero");

	a_acc_sum: assert property (
		isAcc
		|=> destOne == $past({{16{accumulatorOne[31]}},
				accumulatorOne[31:16]})
			+ $past({{16{accumulatorOne[15]}}, accumulatorOne[15:0]})
			&& destOneWrite)
		else $error("accumulator extraction sum wrong");

	a_quad_lanes: assert property (
		isQuad
		|=> destZero[31:16] == $past({8'h00, ySrc[15:8]})
				+ $past({8'h00, zSrc[15:8]})
			&& destOne[15:0] == $past({8'h00, ySrc[23:16]})
				+ $past({8'h00, zSrc[23:16]}))
		else $error("quad add lane sums wrong");

	a_align_window: assert property (
		srcZeroPair == pxa_pkg::PAIR_R10 && !reversePairOrder
		&& indexRegZero[1:0] == 2'h1
		|-> ySrc == {pairZeroHigh[7:0], pairZeroLow[31:8]})
		else $error("pair alignment window wrong");

	a_reverse_swap: assert property (
		srcOnePair == pxa_pkg::PAIR_R32 && reversePairOrder
		&& indexRegOne[1:0] == 2'h3
		|-> zSrc == {pairOneLow[23:0], pairOneHigh[31:24]})
		else $error("reversed pair order wrong");

	a_exc_suppress: assert property (
		(isClip || isQuad) |=> alignExcSuppress && resultValid)
		else $error("alignment exception not suppressed");

	// Result of the first op stands on the second issue cycle
	a_back_to_back: assert property (
		opValid [*2] |-> resultValid ##1 resultValid)
		else $error("back-to-back operation lost");

	a_acc_sum_zero: assert property (
		isAcc
		|=> destZero == $past({{16{accumulatorZero[31]}},
				accumulatorZero[31:16]})
			+ $past({{16{accumulatorZero[15]}}, accumulatorZero[15:0]}))
		else $error("accumulator zero extraction sum wrong");

	a_quad_outer: assert property (
		isQuad
		|=> destZero[15:0] == $past({8'h00, ySrc[7:0]})
				+ $past({8'h00, zSrc[7:0]})
			&& destOne[31:16] == $past({8'h00, ySrc[31:24]})
				+ $past({8'h00, zSrc[31:24]}))
		else $error("quad add outer lane sums wrong");

	a_clip_one_dest: assert property (
		isClip |=> !destOneWrite && destOne == 32'h0000_0000)
		else $error("add/clip wrote a second destination");

	c_clip_high: cover property (isClip && highBytePlacement);
	c_acc_ext: cover property (isAcc ##1 resultValid);
	c_quad_rev: cover property (isQuad && reversePairOrder);
	c_clip_sat: cover property (isClip && sumLo > 32'sh0000_00ff);

endmodule : pxa_simd_unit

// ==== verification/pxa_core_model.sv ====
// Register file model of the issuing core: pairs, index regs, accumulators
`timescale 1ns/100ps
module pxa_core_model (
	output logic [31:0] pairZeroLow,
	output logic [31:0] pairZeroHigh,
	output logic [31:0] pairOneLow,
	output logic [31:0] pairOneHigh,
	output logic [31:0] indexRegZero,
	output logic [31:0] indexRegOne,
	output logic [39:0] accumulatorZero,
	output logic [39:0] accumulatorOne
);
	logic [31:0] regFile [0:5];
	logic [39:0] accFile [0:1];

	// ==========================================================
	// Only R1:0 and R3:2 are wired up as source pairs
	// ==========================================================
	assign pairZeroLow     = regFile[0];
	assign pairZeroHigh    = regFile[1];
	assign pairOneLow      = regFile[2];
	assign pairOneHigh     = regFile[3];
	assign indexRegZero    = regFile[4];
	assign indexRegOne     = regFile[5];
	assign accumulatorZero = accFile[0];
	assign accumulatorOne  = accFile[1];

	// Indices 6 and 7 address the accumulators
	task automatic write_reg(input int idx, input logic [63:0] val);
		if (idx < 6) begin
			regFile[idx] = val[31:0];
		end else begin
			accFile[idx-6] = val[39:0];
		end
	endtask : write_reg

	initial begin
		for (int i = 0; i < 8; i++) begin
			write_reg(i, 64'h0);
		end
	end
endmodule : pxa_core_model

// ==== verification/test_pixel_simd_add_unit.sv ====
// Self-checking bench for the pixel SIMD add unit
`timescale 1ns/100ps
module test_pixel_simd_add_unit;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic opValid = 1'b0;
	pxa_pkg::pxa_op_t opSel = pxa_pkg::PXA_OP_ADD_CLIP;
	logic hiP = 1'b0, rev = 1'b0, ySel = 1'b0, zSel = 1'b0;
	logic [31:0] p0l, p0h, p1l, p1h, ix0, ix1, d0, d1;
	logic [39:0] ac0, ac1;
	logic rv, dw, sup;
	int n_fail = 0, checks = 0, cycleNo = 0;
	logic [65:0] expQ [$];
	int cycQ [$];
	logic [31:0] rf [0:5];
	logic [39:0] af [0:1];
	pxa_pkg::pxa_op_t ops [3] = '{pxa_pkg::PXA_OP_ADD_CLIP,
		pxa_pkg::PXA_OP_ACC_EXT, pxa_pkg::PXA_OP_QUAD_ADD};

	always #5 core_clk = ~core_clk;
	always @(posedge core_clk) cycleNo <= cycleNo + 1;

	pxa_core_model core_u (.pairZeroLow(p0l), .pairZeroHigh(p0h),
		.pairOneLow(p1l), .pairOneHigh(p1h), .indexRegZero(ix0),
		.indexRegOne(ix1), .accumulatorZero(ac0), .accumulatorOne(ac1));
	pxa_simd_unit dut_u (.core_clk(core_clk), .srst(srst),
		.opValid(opValid), .opSel(opSel), .highBytePlacement(hiP),
		.reversePairOrder(rev), .srcZeroPair(ySel), .srcOnePair(zSel),
		.pairZeroLow(p0l), .pairZeroHigh(p0h), .pairOneLow(p1l),
		.pairOneHigh(p1h), .indexRegZero(ix0), .indexRegOne(ix1),
		.accumulatorZero(ac0), .accumulatorOne(ac1), .resultValid(rv),
		.destZero(d0), .destOne(d1), .destOneWrite(dw),
		.alignExcSuppress(sup));

	// ==========================================================
	// Reference arithmetic
	// ==========================================================
	function automatic logic [7:0] clip(input logic [7:0] b,
		input logic [15:0] h);
		logic signed [31:0] s;
		s = $signed({24'h0, b}) + $signed({{16{h[15]}}, h});
		clip = (s < 0) ? 8'h00 : (s > 255) ? 8'hff : s[7:0];
	endfunction : clip

	function automatic logic [31:0] pick(input logic [31:0] lo, hi,
		input logic [1:0] n, input logic r);
		logic [63:0] c;
		c = r ? {lo, hi} : {hi, lo};
		pick = c[8*n +: 32];
	endfunction : pick

	function automatic logic [31:0] accSum(input logic [39:0] a);
		accSum = {{16{a[31]}}, a[31:16]} + {{16{a[15]}}, a[15:0]};
	endfunction : accSum

	function automatic logic [15:0] qs(input logic [7:0] a, b);
		qs = {8'h00, a} + {8'h00, b};
	endfunction : qs

	task automatic put(input int i, input logic [63:0] v);
		if (i < 6) rf[i] = v[31:0];
		else af[i-6] = v[39:0];
		core_u.write_reg(i, v);
	endtask : put

	task automatic check(input logic [65:0] got, exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// ==========================================================
	// Driver: one operation per call, notes the expected result
	// ==========================================================
	task automatic issue(input pxa_pkg::pxa_op_t op, input logic h, r,
		ys, zs, rnd, input logic [1:0] a0, a1);
		logic [31:0] y, z, v, e0, e1;
		logic [1:0] f;
		if (rnd) begin
			for (int i = 0; i < 4; i++) begin
				v = $urandom;
				case ($urandom_range(2))
					0: put(i, {32'h0, v & 32'h00ff00ff});
					1: put(i, {32'h0, v | 32'hff00ff00});
					default: put(i, {32'h0, v});
				endcase
			end
			put(6, {$urandom, $urandom});
			put(7, {$urandom, $urandom});
		end
		put(4, {32'h0, ($urandom & 32'hfffffffc) | a0});
		put(5, {32'h0, ($urandom & 32'hfffffffc) | a1});
		y = ys ? pick(rf[2], rf[3], a1, r) : pick(rf[0], rf[1], a0, r);
		z = zs ? pick(rf[2], rf[3], a1, r) : pick(rf[0], rf[1], a0, r);
		case (op)
			pxa_pkg::PXA_OP_ADD_CLIP: begin
				v = {clip(y[15:8], z[31:16]), clip(y[7:0], z[15:0]), 16'h0};
				e0 = h ? {v[31:24], 8'h00, v[23:16], 8'h00}
					: {8'h00, v[31:24], 8'h00, v[23:16]};
				e1 = 32'h0;
				f = 2'b01;
			end
			pxa_pkg::PXA_OP_ACC_EXT: begin
				e0 = accSum(af[0]);
				e1 = accSum(af[1]);
				f = 2'b10;
			end
			default: begin
				e0 = {qs(y[15:8], z[15:8]), qs(y[7:0], z[7:0])};
				e1 = {qs(y[31:24], z[31:24]), qs(y[23:16], z[23:16])};
				f = 2'b11;
			end
		endcase
		opValid = 1'b1;
		opSel = op;
		{hiP, rev, ySel, zSel} = {h, r, ys, zs};
		expQ.push_back({e0, e1, f});
		cycQ.push_back(cycleNo + 1);
		@(posedge core_clk);
		#1;
	endtask : issue

	task automatic idle(input int n);
		opValid = 1'b0;
		repeat (n) @(posedge core_clk);
		#1;
	endtask : idle

	task automatic print_verdict;
		if (n_fail == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : print_verdict

	// ==========================================================
	// Monitor: results must match the oldest note, one cycle late
	// ==========================================================
	always @(posedge core_clk) begin
		#2;
		if (rv === 1'b1 && expQ.size() > 0) begin
			check(66'(cycleNo), 66'(cycQ.pop_front()));
			check({d0, d1, dw, sup}, expQ.pop_front());
		end else if (rv === 1'b1) begin
			check(66'(rv), 66'h0);
		end else begin
			check(66'({dw, sup}), 66'h0);
		end
	end

	initial begin
		repeat (20000) @(posedge core_clk);
		n_fail++;
		print_verdict();
	end

	initial begin
		logic [31:0] yw [4] = '{32'h0000ffff, 32'h0, 32'h0000ff01,
			32'h000080ff};
		logic [31:0] zw [4] = '{32'h7fff7fff, 32'h80008000, 32'h0000ffff,
			32'h00800001};
		void'($urandom(32'ha21065a2));
		repeat (5) @(posedge core_clk);
		#1;
		srst = 1'b0;
		// Clip boundaries: saturate high, low, and exact 255 and 0
		for (int i = 0; i < 4; i++) begin
			put(0, {32'h0, yw[i]});
			put(2, {32'h0, zw[i]});
			issue(ops[0], 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 2'h0, 2'h0);
			issue(ops[0], 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 2'h0, 2'h0);
			issue(ops[2], 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 2'h0, 2'h0);
		end
		// Random mix, mostly back to back
		for (int k = 0; k < 400; k++) begin
			issue(ops[$urandom_range(2)], 1'($urandom), 1'($urandom),
				1'($urandom), 1'($urandom), 1'b1, 2'($urandom),
				2'($urandom));
			if ($urandom_range(3) == 0) idle(1);
		end
		idle(3);
		srst = 1'b1;
		idle(2);
		srst = 1'b0;
		check(66'({d0, d1}), 66'h0);
		issue(ops[1], 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 2'h3, 2'h3);
		// Undefined select: both results zero, second write flagged
		opSel = pxa_pkg::pxa_op_t'(3'h6);
		expQ.push_back({64'h0, 2'b11});
		cycQ.push_back(cycleNo + 1);
		@(posedge core_clk);
		#1;
		idle(4);
		check(66'(expQ.size()), 66'h0);
		print_verdict();
	end
endmodule : test_pixel_simd_add_unit
